// ### dv/dih_bus_master.sv
/*
  Behavioural two-wire bus master that drives the receiver's serial clock
  and pulls the data line low through sda_low.
  Assumes a pull-up on both lines and the bench resolving the data wire.
  Edges follow the falling ref_clk edge, with phases of 60 ns.
*/
`timescale 1ns/100ps
module dih_bus_master (
  // Timing reference
  input wire logic ref_clk,
  // Resolved data line
  input wire logic sda_in,
  // Driven lines
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic start();
    sda_low = 1'b0;
    wt(8);
    scl = 1'b1;
    wt(15);
    sda_low = 1'b1;
    wt(15);
    scl = 1'b0;
    wt(7);
  endtask

  task automatic stop();
    sda_low = 1'b1;
    wt(8);
    scl = 1'b1;
    wt(15);
    sda_low = 1'b0;
    wt(15);
  endtask

  // MSB first, ack slot read 7 cycles after the ninth rising edge
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      wt(8);
      scl = 1'b1;
      wt(15);
      scl = 1'b0;
      wt(7);
    end
    sda_low = 1'b0;
    wt(8);
    scl = 1'b1;
    wt(7);
    ack = (sda_in === 1'b0);
    wt(8);
    scl = 1'b0;
    wt(7);
  endtask
endmodule

// ### dv/testbench.sv
/*
  Self-checking bench of the two-wire write receiver.
  Assumes the bus master model in its own file; the data wire has a
  pull-up and is resolved here from both parties' pull-downs.
*/
`timescale 1ns/100ps
module testbench;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic pin_hi = 1'b0;
  logic pin_lo = 1'b1;
  wire scl;
  wire m_low;
  logic sda_o, sda_oe_n, hs_mode, pd_sel, code_valid;
  logic sd_hi, sd_lo, sd_valid, ack;
  logic [1:0] ext, load, chan;
  logic [11:0] code_word;
  logic [11:0] last_code = 12'h000;
  int err_total = 0;
  int checked = 0;
  int code_cnt = 0;
  int sd_cnt = 0;
  wire sda = (m_low === 1'b1 || (sda_oe_n === 1'b0 && sda_o === 1'b0)) ?
    1'b0 : 1'b1;

  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  dih_bus_master u_dih_bus_master (.ref_clk(ref_clk), .sda_in(sda),
    .scl(scl), .sda_low(m_low));

  dih_write_rx u_dih_write_rx (.ref_clk(ref_clk), .srst(srst),
    .scl_clk(scl), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .addr_pin_hi(pin_hi), .addr_pin_lo(pin_lo),
    .hs_mode(hs_mode), .ctrl_ext(ext), .load_mode(load),
    .chan_sel(chan), .powerdown_data_select(pd_sel),
    .code_word(code_word), .code_valid(code_valid),
    .shutdown_mode_hi(sd_hi), .shutdown_mode_lo(sd_lo),
    .shutdown_valid(sd_valid));

  // Counting every high cycle also catches pulses longer than one cycle
  always @(posedge ref_clk) begin
    if (code_valid === 1'b1) begin
      code_cnt++;
      last_code = code_word;
    end
    if (sd_valid === 1'b1) begin
      sd_cnt++;
    end
  end

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic tx(input logic [7:0] b, input logic exp);
    u_dih_bus_master.send(b, ack);
    chk(ack, exp);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk);
    err_total++;
    $display("wrong value at %0t: run did not complete", $time);
    wrap_up();
  end

  initial begin
    repeat (5) @(negedge ref_clk);
    srst = 1'b0;
    repeat (6) @(negedge ref_clk);
    chk(sda_oe_n, 1'b1);
    chk(hs_mode, 1'b0);
    chk(code_valid, 1'b0);
    $display("test reset done");

    // Standard speed: two code pairs, then a lone high byte
    u_dih_bus_master.start();
    tx(8'h9A, 1'b1);
    tx(8'h34, 1'b1);
    tx(8'hAB, 1'b1);
    tx(8'hC5, 1'b1);
    tx(8'h12, 1'b1);
    tx(8'h3F, 1'b1);
    tx(8'h77, 1'b1);
    u_dih_bus_master.stop();
    chk(load, 2'h3);
    chk(chan, 2'h2);
    chk(pd_sel, 1'b0);
    chk(code_cnt, 12'h002);
    chk(last_code, 12'h123);
    chk(hs_mode, 1'b0);
    $display("test standard write done");

    // High speed: master code, power-down bytes, one byte too many
    u_dih_bus_master.start();
    tx(8'h0D, 1'b0);
    u_dih_bus_master.start();
    chk(hs_mode, 1'b1);
    tx(8'h9A, 1'b1);
    tx(8'hC3, 1'b1);
    tx(8'h80, 1'b1);
    tx(8'h0F, 1'b1);
    tx(8'h00, 1'b0);
    chk(ext, 2'h3);
    chk(load, 2'h0);
    chk(chan, 2'h1);
    chk(pd_sel, 1'b1);
    chk(sd_hi, 1'b1);
    chk(sd_lo, 1'b0);
    chk(sd_cnt, 12'h001);
    u_dih_bus_master.start();
    chk(hs_mode, 1'b1);
    tx(8'h9A, 1'b1);
    u_dih_bus_master.stop();
    repeat (10) @(negedge ref_clk);
    chk(hs_mode, 1'b0);
    chk(code_cnt, 12'h002);
    $display("test high speed write done");

    // Straps changed: old address and read bit refused, high-speed codes
    pin_hi = 1'b1;
    pin_lo = 1'b0;
    repeat (10) @(negedge ref_clk);
    u_dih_bus_master.start();
    tx(8'h9A, 1'b0);
    u_dih_bus_master.stop();
    u_dih_bus_master.start();
    tx(8'h9D, 1'b0);
    u_dih_bus_master.stop();
    u_dih_bus_master.start();
    tx(8'h08, 1'b0);
    u_dih_bus_master.start();
    chk(hs_mode, 1'b1);
    tx(8'h9C, 1'b1);
    tx(8'h00, 1'b1);
    tx(8'hFF, 1'b1);
    tx(8'hF0, 1'b1);
    u_dih_bus_master.stop();
    chk(code_cnt, 12'h003);
    chk(last_code, 12'hFFF);
    $display("test address select done");
    wrap_up();
  end
endmodule

// ### verilog/dih_bit_capture.sv
/*
  Link-side bit capture, clocked by the bus serial clock itself.
  Each rising serial clock edge shifts the data line into an 8-bit
  register. The system side learns of each edge from its own filtered
  copy of the serial clock and reads the register a few cycles later.
  Assumes the serial clock only runs during frames and that its phases
  last long enough for the register to be stable whenever it is read.
*/
`timescale 1ns/100ps
module dih_bit_capture (
  // Link clock
  input wire logic scl_clk,
  // Serial data in
  input wire logic sda_i,
  // Captured bits
  output logic [7:0] shift_out
);
  logic [7:0] shift_q, shift_d;

  // No reset: the serial clock need not run during reset, and every
  // byte overwrites all eight bits before the system side reads them
  always_comb begin
    shift_d = {shift_q[6:0], sda_i};
  end

  always_ff @(posedge scl_clk) begin
    shift_q <= shift_d;
  end

  assign shift_out = shift_q;
endmodule

// ### verilog/dih_pkg.sv
/*
  Shared constants and types of the high-speed two-wire write receiver:
  address and master-code prefixes, byte field positions, bit counts and
  the byte-level state enumeration.
  Assumes a single compile unit; nothing is imported, users write
  dih_pkg::name.
*/
package dih_pkg;
  // Upper five bits of a device address and of the high-speed master code
  localparam logic [4:0] ADDR_PREFIX = 5'h13;
  localparam logic [4:0] MCODE_PREFIX = 5'h01;
  // Bit positions inside a received byte
  localparam int PREFIX_LSB = 3;
  localparam int PIN_HI_BIT = 2;
  localparam int PIN_LO_BIT = 1;
  localparam int DIR_BIT = 0;
  localparam int PD_SEL_BIT = 0;
  localparam int CHAN_LSB = 1;
  localparam int LOAD_LSB = 4;
  localparam int EXT_LSB = 6;
  localparam int MODE_LSB = 6;
  localparam int NIBBLE_LSB = 4;
  // Widths
  localparam int CODE_W = 12;
  localparam int FIELD_W = 2;
  localparam int CNT_W = 4;
  // Bit counter marks: last data bit index and the ack slot
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  // Level driven on the data line while acknowledging
  localparam logic SDA_LOW = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CTRL,
    ST_CODE_HI,
    ST_CODE_LO,
    ST_PD_HI,
    ST_PD_LO,
    ST_SKIP
  } dih_state_type;
endpackage

// ### verilog/dih_sync3.sv
/*
  Three-flop input synchroniser with agreement filter, W bits wide.
  The output only follows a bit once the second and third stages agree.
  Assumes din is asynchronous to clk; srst is synchronous to clk.
*/
`timescale 1ns/100ps
module dih_sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Asynchronous levels in, filtered levels out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_q, s2_q, s3_q, out_q;
  logic [W-1:0] s1_d, s2_d, s3_d, out_d;

  always_comb begin
    s1_d = din;
    s2_d = s1_q;
    s3_d = s2_q;
    // Stage one is seen only by stage two
    out_d = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & out_q);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      out_q <= out_d;
    end
  end

  assign dout = out_q;
endmodule

// ### verilog/dih_write_rx.sv
/*
  Write receiver of a two-wire bus slave for a quad 12-bit converter,
  covering standard/fast and high-speed mode. Bits are captured on the
  serial clock; framing, acknowledge and decoding run on ref_clk.
  Assumes an open-drain data line resolved outside from sda_oe_n and
  scl_i/scl_clk being the same bus serial clock pin.

  // Summary of operation
  // [R1] The master opens high-speed writes with a 00001xxx master code.
  // [R2] The master code is never acknowledged by this device.
  // [R3] The master then repeats start and sends a write address.
  // [R4] An address 10011 plus matching pin bits and write bit is acked.
  // [R5] The control byte after the address is acknowledged.
  // [R6] Control bits give update mode, channel and the power-down select.
  // [R7] With select clear, acked high/low pairs build 12-bit codes.
  // [R8] With select set, exactly two power-down bytes are acked.
  // [R9] The master places the shutdown mode in bits 7:6 of byte one.
  // [R10] The master ends a write with a stop or repeated start.
  // [R11] Standard/fast writes follow the same order without master code.
  // [R12] A stop returns the receiver to standard/fast operation.
*/
`timescale 1ns/100ps
module dih_write_rx (
  // System clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Two-wire bus
  input wire logic scl_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // Address-select straps
  input wire logic addr_pin_hi,
  input wire logic addr_pin_lo,
  // Speed mode and decoded control byte
  output logic hs_mode,
  output logic [1:0] ctrl_ext,
  output logic [1:0] load_mode,
  output logic [1:0] chan_sel,
  output logic powerdown_data_select,
  // Conversion code
  output logic [11:0] code_word,
  output logic code_valid,
  // Power-down data
  output logic shutdown_mode_hi,
  output logic shutdown_mode_lo,
  output logic shutdown_valid
);
  logic [7:0] shift_raw;
  logic scl_s, sda_s;
  logic [1:0] bus_n_s, pins_s;
  logic scl_p_q, sda_p_q;
  logic start_ev, stop_ev, bit_ev, scl_fall, byte_ev;
  logic [7:0] rx_byte;
  dih_pkg::dih_state_type state_q, state_d;
  logic [3:0] bitcnt_q, bitcnt_d;
  logic ack_pend_q, ack_pend_d, ack_drv_q, ack_drv_d;
  logic hs_q, hs_d;
  logic [7:0] code_hi_q, code_hi_d;
  logic [1:0] pd_hold_q, pd_hold_d, shut_q, shut_d;
  logic [1:0] ext_q, ext_d, load_q, load_d, chan_q, chan_d;
  logic pdsel_q, pdsel_d;
  logic [11:0] code_q, code_d;
  logic cval_q, cval_d, sval_q, sval_d;
  logic is_mcode, is_addr;

  dih_bit_capture u_capture (
    .scl_clk(scl_clk),
    .sda_i(sda_i),
    .shift_out(shift_raw)
  );

  // Bus lines idle high, so they pass the filter inverted: its reset
  // level then matches the idle bus and no false edge follows reset
  dih_sync3 #(.W(2)) u_sync_bus (
    .clk(ref_clk),
    .srst(srst),
    .din({~scl_i, ~sda_i}),
    .dout(bus_n_s)
  );

  dih_sync3 #(.W(2)) u_sync_pins (
    .clk(ref_clk),
    .srst(srst),
    .din({addr_pin_hi, addr_pin_lo}),
    .dout(pins_s)
  );

  assign scl_s = ~bus_n_s[1];
  assign sda_s = ~bus_n_s[0];
  // Stable once the filtered rising edge is seen: no serial edge between
  assign rx_byte = shift_raw;
  assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_ev = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign bit_ev = scl_s & ~scl_p_q;
  assign scl_fall = scl_p_q & ~scl_s;
  assign byte_ev = bit_ev & (bitcnt_q == dih_pkg::LAST_DATA_BIT);
  assign is_mcode = ~hs_q &
    (rx_byte[7:dih_pkg::PREFIX_LSB] == dih_pkg::MCODE_PREFIX);
  assign is_addr =
    (rx_byte[7:dih_pkg::PREFIX_LSB] == dih_pkg::ADDR_PREFIX) &&
    (rx_byte[dih_pkg::PIN_HI_BIT:dih_pkg::PIN_LO_BIT] == pins_s) &&
    !rx_byte[dih_pkg::DIR_BIT];

  always_comb begin
    state_d = state_q;
    bitcnt_d = bitcnt_q;
    ack_pend_d = ack_pend_q;
    ack_drv_d = ack_drv_q;
    hs_d = hs_q;
    code_hi_d = code_hi_q;
    pd_hold_d = pd_hold_q;
    shut_d = shut_q;
    ext_d = ext_q;
    load_d = load_q;
    chan_d = chan_q;
    pdsel_d = pdsel_q;
    code_d = code_q;
    cval_d = 1'b0;
    sval_d = 1'b0;
    if (start_ev) begin
      // Repeated start loops back to write addressing
      state_d = dih_pkg::ST_ADDR;
      bitcnt_d = dih_pkg::CNT_ZERO;
      ack_pend_d = 1'b0;
      ack_drv_d = 1'b0;
    end else if (stop_ev) begin
      // [R12] stop leaves high speed
      state_d = dih_pkg::ST_IDLE;
      hs_d = 1'b0;
      bitcnt_d = dih_pkg::CNT_ZERO;
      ack_pend_d = 1'b0;
      ack_drv_d = 1'b0;
    end else begin
      if (bit_ev) begin
        if (bitcnt_q == dih_pkg::ACK_SLOT) begin
          bitcnt_d = dih_pkg::CNT_ZERO;
        end else begin
          bitcnt_d = bitcnt_q + dih_pkg::CNT_ONE;
        end
      end
      // Drive after the eighth falling edge, release after the ninth
      if (scl_fall) begin
        if (ack_pend_q) begin
          ack_drv_d = 1'b1;
          ack_pend_d = 1'b0;
        end else if (bitcnt_q == dih_pkg::CNT_ZERO) begin
          ack_drv_d = 1'b0;
        end
      end
      if (byte_ev) begin
        unique case (state_q)
          dih_pkg::ST_ADDR: begin
            if (is_mcode) begin
              // [R2] master code left unacked
              hs_d = 1'b1;
              state_d = dih_pkg::ST_IDLE;
            end else if (is_addr) begin
              // [R4] [R11] write address acked
              ack_pend_d = 1'b1;
              state_d = dih_pkg::ST_CTRL;
            end else begin
              state_d = dih_pkg::ST_SKIP;
            end
          end
          dih_pkg::ST_CTRL: begin
            // [R5] [R6] control byte acked and decoded
            ack_pend_d = 1'b1;
            ext_d = rx_byte[dih_pkg::EXT_LSB +: dih_pkg::FIELD_W];
            load_d = rx_byte[dih_pkg::LOAD_LSB +: dih_pkg::FIELD_W];
            chan_d = rx_byte[dih_pkg::CHAN_LSB +: dih_pkg::FIELD_W];
            pdsel_d = rx_byte[dih_pkg::PD_SEL_BIT];
            state_d = rx_byte[dih_pkg::PD_SEL_BIT] ? dih_pkg::ST_PD_HI
                                                    : dih_pkg::ST_CODE_HI;
          end
          dih_pkg::ST_CODE_HI: begin
            // [R7] high byte of a code pair
            ack_pend_d = 1'b1;
            code_hi_d = rx_byte;
            state_d = dih_pkg::ST_CODE_LO;
          end
          dih_pkg::ST_CODE_LO: begin
            // [R7] low nibble completes the code, pairs repeat
            ack_pend_d = 1'b1;
            code_d = {code_hi_q, rx_byte[7:dih_pkg::NIBBLE_LSB]};
            cval_d = 1'b1;
            state_d = dih_pkg::ST_CODE_HI;
          end
          dih_pkg::ST_PD_HI: begin
            // [R8] first power-down byte
            ack_pend_d = 1'b1;
            pd_hold_d = rx_byte[dih_pkg::MODE_LSB +: dih_pkg::FIELD_W];
            state_d = dih_pkg::ST_PD_LO;
          end
          dih_pkg::ST_PD_LO: begin
            // [R8] second byte, then further bytes go unacked
            ack_pend_d = 1'b1;
            shut_d = pd_hold_q;
            sval_d = 1'b1;
            state_d = dih_pkg::ST_SKIP;
          end
          dih_pkg::ST_IDLE, dih_pkg::ST_SKIP: begin
            state_d = state_q;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      state_q <= dih_pkg::ST_IDLE;
      bitcnt_q <= dih_pkg::CNT_ZERO;
      ack_pend_q <= 1'b0;
      ack_drv_q <= 1'b0;
      hs_q <= 1'b0;
      code_hi_q <= '0;
      pd_hold_q <= '0;
      shut_q <= '0;
      ext_q <= '0;
      load_q <= '0;
      chan_q <= '0;
      pdsel_q <= 1'b0;
      code_q <= '0;
      cval_q <= 1'b0;
      sval_q <= 1'b0;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      state_q <= state_d;
      bitcnt_q <= bitcnt_d;
      ack_pend_q <= ack_pend_d;
      ack_drv_q <= ack_drv_d;
      hs_q <= hs_d;
      code_hi_q <= code_hi_d;
      pd_hold_q <= pd_hold_d;
      shut_q <= shut_d;
      ext_q <= ext_d;
      load_q <= load_d;
      chan_q <= chan_d;
      pdsel_q <= pdsel_d;
      code_q <= code_d;
      cval_q <= cval_d;
      sval_q <= sval_d;
    end
  end

  assign sda_o = dih_pkg::SDA_LOW;
  assign sda_oe_n = ~ack_drv_q;
  assign hs_mode = hs_q;
  assign ctrl_ext = ext_q;
  assign load_mode = load_q;
  assign chan_sel = chan_q;
  assign powerdown_data_select = pdsel_q;
  assign code_word = code_q;
  assign code_valid = cval_q;
  assign shutdown_mode_hi = shut_q[1];
  assign shutdown_mode_lo = shut_q[0];
  assign shutdown_valid = sval_q;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  logic mc_ev, addr_ev, ctrl_ev, lo_ev, pdlo_ev;
  assign mc_ev = byte_ev && !start_ev && !stop_ev &&
    state_q == dih_pkg::ST_ADDR && is_mcode;
  assign addr_ev = byte_ev && !start_ev && !stop_ev &&
    state_q == dih_pkg::ST_ADDR && !is_mcode && is_addr;
  assign ctrl_ev = byte_ev && !start_ev && !stop_ev &&
    state_q == dih_pkg::ST_CTRL;
  assign lo_ev = byte_ev && !start_ev && !stop_ev &&
    state_q == dih_pkg::ST_CODE_LO;
  assign pdlo_ev = byte_ev && !start_ev && !stop_ev &&
    state_q == dih_pkg::ST_PD_LO;

  a_mcode_no_ack: assert property ( // [R2]
    mc_ev |=> (hs_q && !ack_pend_q && sda_oe_n)[*8])
    else $error("master code was acknowledged");
  a_addr_ack: assert property ( // [R4]
    addr_ev |=> ack_pend_q && state_q == dih_pkg::ST_CTRL)
    else $error("matching write address not acked");
  a_addr_fs: assert property ( // [R11]
    addr_ev && !hs_q |=> !hs_q && state_q == dih_pkg::ST_CTRL)
    else $error("standard speed address not handled");
  a_ctrl_ack: assert property ( // [R5]
    ctrl_ev |=> ack_pend_q)
    else $error("control byte not acked");
  a_ctrl_decode: assert property ( // [R6]
    ctrl_ev |=> chan_sel == $past(rx_byte[2:1]) &&
      load_mode == $past(rx_byte[5:4]) &&
      (state_q == ($past(rx_byte[0]) ? dih_pkg::ST_PD_HI
                                      : dih_pkg::ST_CODE_HI)))
    else $error("control byte decoded wrongly");
  a_code_pair: assert property ( // [R7]
    lo_ev |=> code_valid && code_word[3:0] == $past(rx_byte[7:4]) &&
      code_word[11:4] == $past(code_hi_q) &&
      state_q == dih_pkg::ST_CODE_HI)
    else $error("code pair not assembled");
  a_pd_two_bytes: assert property ( // [R8]
    pdlo_ev |=> shutdown_valid && ack_pend_q &&
      state_q == dih_pkg::ST_SKIP)
    else $error("power-down byte pair mishandled");
  a_stop_revert: assert property ( // [R12]
    stop_ev |=> !hs_mode && state_q == dih_pkg::ST_IDLE && sda_oe_n)
    else $error("stop did not revert receiver");
  a_ack_release: assert property ( // [R7]
    ack_drv_q && scl_fall && !ack_pend_q && bitcnt_q == dih_pkg::CNT_ZERO
      && !start_ev && !stop_ev |=> sda_oe_n)
    else $error("acknowledge not released");

  c_hs_entry: cover property (mc_ev ##[1:1000] addr_ev);
  c_code_write: cover property (lo_ev ##1 code_valid);
  c_pd_write: cover property (pdlo_ev ##1 shutdown_valid);
  c_stop: cover property (hs_q ##1 stop_ev);
endmodule
